// ### verilog/fault_restart_supervisor.sv
// trip supervision, restart countdown, display feed and AXI4-Lite registers
`timescale 1ns/1ns
module fault_restart_supervisor #(
    parameter int unsigned SEC_CYCLES_P = fault_restart_pkg::SEC_CYCLES
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire fault_restart_pkg::trip_inputs_t trip_in,
    input wire logic key_up_pin,
    input wire logic key_down_pin,
    input wire logic restart_permit_pin,
    output fault_restart_pkg::display_t disp,
    output logic restart_pulse,
    output logic auto_mode,
    output logic irq
);
    import fault_restart_pkg::*;

    sup_regs_t r;
    sup_regs_t n;
    logic [5:0] cond;
    logic [2:0] first_code;
    logic gesture;
    logic mem_clr;

    function automatic logic [2:0] first_set(input logic [5:0] v);
        logic [2:0] f;
        f = 3'h0;
        for (int i = N_TYPES - 1; i >= 0; i--) begin
            if (v[i]) begin
                f = 3'(i);
            end
        end
        return f;
    endfunction

    function automatic logic [1:0] rst_idx(input logic [2:0] code);
        logic [2:0] d;
        d = code - T_FIRST_RST;
        return d[1:0];
    endfunction

    function automatic logic [31:0] byte_mask(input logic [3:0] strb);
        logic [31:0] m;
        m = 32'h0000_0000;
        for (int b = 0; b < 4; b++) begin
            m[b*8 +: 8] = {8{strb[b]}};
        end
        return m;
    endfunction

    function automatic logic [127:0] trip_text(input logic [2:0] code);
        logic [127:0] t;
        unique case (code)
            T_OUT_SHORT: t = MSG_OUT_SHORT;
            T_LINE_OC: t = MSG_LINE_OC;
            T_OVERTEMP: t = MSG_OVERTEMP;
            T_BUS_OV: t = MSG_BUS_OV;
            T_LOW_CUR: t = MSG_LOW_CUR;
            T_PHASE_LOSS: t = MSG_PHASE;
            default: t = MSG_BLANK;
        endcase
        return t;
    endfunction

    // one character of the 2 x 32 frame; texts fill the left half of each row
    function automatic logic [7:0] disp_char(input sup_state_t st, input logic [2:0] code,
                                             input logic [7:0] secs, input logic [5:0] pos);
        logic [127:0] txt;
        logic [4:0] col;
        logic [7:0] ch;
        col = pos[4:0];
        txt = MSG_BLANK;
        if (!pos[5]) begin
            txt = (st == ST_IDLE) ? MSG_READY : trip_text(code);
        end else if (st == ST_COUNTDOWN) begin
            txt = MSG_RESTART;
        end else if (st == ST_HELD) begin
            txt = NON_RESTARTABLE[code] ? MSG_CYCLE : MSG_CLEAR;
        end
        ch = col[4] ? 8'h20 : txt[127 - 8 * col[3:0] -: 8];
        if (pos[5] && st == ST_COUNTDOWN) begin
            if (col == 5'(DIGIT_COL)) begin
                ch = 8'h30 + (secs / 8'h64);
            end else if (col == 5'(DIGIT_COL + 1)) begin
                ch = 8'h30 + ((secs / 8'h0A) % 8'h0A);
            end else if (col == 5'(DIGIT_COL + 2)) begin
                ch = 8'h30 + (secs % 8'h0A);
            end
        end
        return ch;
    endfunction

    assign cond[T_OUT_SHORT] = trip_in.out_short;
    assign cond[T_LINE_OC] = trip_in.line_oc;
    assign cond[T_OVERTEMP] = trip_in.overtemp;
    assign cond[T_BUS_OV] = trip_in.bus_ov;
    assign cond[T_LOW_CUR] = trip_in.motor_current < r.thresh;
    assign cond[T_PHASE_LOSS] = trip_in.unbalance_pct > UNBAL_LIMIT_PCT;
    assign first_code = first_set(cond);
    assign gesture = r.key_up && r.key_dn && !r.both_d;

    always_comb begin
        logic [31:0] m;
        logic [31:0] wv;
        logic [7:0] tbase;
        logic [1:0] ix;
        logic nonrst_held;
        n = r;
        mem_clr = 1'b0;
        m = 32'h0000_0000;
        wv = 32'h0000_0000;
        tbase = 8'h00;
        ix = 2'h0;
        nonrst_held = 1'b0;
        n.restart = 1'b0;

        // keys and permit arrive from pins: three stages, accept on agreement
        n.up_s = {r.up_s[1:0], key_up_pin};
        n.dn_s = {r.dn_s[1:0], key_down_pin};
        n.pm_s = {r.pm_s[1:0], restart_permit_pin};
        if (r.up_s[1] == r.up_s[2]) begin
            n.key_up = r.up_s[2];
        end
        if (r.dn_s[1] == r.dn_s[2]) begin
            n.key_dn = r.dn_s[2];
        end
        if (r.pm_s[1] == r.pm_s[2]) begin
            n.permit = r.pm_s[2];
        end
        n.both_d = r.key_up && r.key_dn;

        // wait until the permit has settled before choosing the start mode
        if (r.boot != 3'h7) begin
            n.boot = r.boot + 3'h1;
        end
        if (r.boot == 3'h6) begin
            n.auto_mode = n.permit;
        end

        // register bus, write side
        if (r.bvalid && s_axi_bready) begin
            n.bvalid = 1'b0;
        end
        if (s_axi_awvalid && r.awready) begin
            n.aw_got = 1'b1;
            n.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && r.wready) begin
            n.w_got = 1'b1;
            n.wdata = s_axi_wdata;
            n.wstrb = s_axi_wstrb;
        end
        if (n.aw_got && n.w_got && !n.bvalid) begin
            m = byte_mask(n.wstrb);
            wv = n.wdata & m;
            n.bvalid = 1'b1;
            n.bresp = RESP_OKAY;
            n.aw_got = 1'b0;
            n.w_got = 1'b0;
            unique case (n.awaddr[7:2])
                ADDR_CTRL[7:2]: begin
                    if (m[CTRL_AUTO_BIT]) begin
                        n.auto_mode = wv[CTRL_AUTO_BIT];
                    end
                    mem_clr = wv[CTRL_MEMCLR_BIT];
                end
                ADDR_STATUS[7:2]: n.status = r.status & ~wv[5:0];
                ADDR_MASK[7:2]: n.mask = (r.mask & ~m[5:0]) | wv[5:0];
                ADDR_THRESH[7:2]: n.thresh = (r.thresh & ~m[15:0]) | wv[15:0];
                ADDR_STATE[7:2], ADDR_TALLY0[7:2], ADDR_TALLY1[7:2],
                ADDR_HIST[7:2], ADDR_HPTR[7:2]: n.bresp = RESP_OKAY;
                default: begin
                    if (n.awaddr[7:4] == ADDR_RCFG0[7:4]) begin
                        ix = n.awaddr[3:2];
                        n.limit[ix] = (r.limit[ix] & ~m[7:0]) | wv[7:0];
                        n.delay[ix] = (r.delay[ix] & ~m[15:8]) | wv[15:8];
                    end else begin
                        n.bresp = RESP_SLVERR;
                    end
                end
            endcase
        end
        n.awready = !n.aw_got && !n.bvalid;
        n.wready = !n.w_got && !n.bvalid;

        // register bus, read side
        if (r.rvalid && s_axi_rready) begin
            n.rvalid = 1'b0;
        end
        if (s_axi_arvalid && r.arready) begin
            n.rvalid = 1'b1;
            n.rresp = RESP_OKAY;
            n.rdata = 32'h0000_0000;
            unique case (s_axi_araddr[7:2])
                ADDR_CTRL[7:2]: n.rdata[CTRL_AUTO_BIT] = r.auto_mode;
                ADDR_STATUS[7:2]: n.rdata[5:0] = r.status;
                ADDR_MASK[7:2]: n.rdata[5:0] = r.mask;
                ADDR_STATE[7:2]: n.rdata = {14'h0000, r.auto_mode, r.permit, r.secs,
                                            3'h0, r.code, 2'(r.st)};
                ADDR_THRESH[7:2]: n.rdata[15:0] = r.thresh;
                ADDR_TALLY0[7:2]: n.rdata = r.tally[3:0];
                ADDR_TALLY1[7:2]: n.rdata[15:0] = r.tally[5:4];
                ADDR_HIST[7:2]: n.rdata = r.hist;
                ADDR_HPTR[7:2]: n.rdata[2:0] = r.hptr;
                default: begin
                    if (s_axi_araddr[7:4] == ADDR_RCFG0[7:4]) begin
                        n.rdata[15:0] = {r.delay[s_axi_araddr[3:2]], r.limit[s_axi_araddr[3:2]]};
                    end else begin
                        n.rresp = RESP_SLVERR;
                    end
                end
            endcase
        end
        n.arready = !n.rvalid;

        if (mem_clr) begin
            n.hist = '0;
            n.hptr = 3'h0;
        end

        // clear gesture; a non-restartable trip ignores it
        nonrst_held = (r.st == ST_HELD) && NON_RESTARTABLE[r.code];
        if (gesture && !nonrst_held) begin
            n.tally = '0;
            if (r.st != ST_IDLE) begin
                n.st = ST_IDLE;
            end
        end

        // sticky events: a new rise wins over a same-cycle clear
        n.cond_d = cond;
        n.status = n.status | (cond & ~r.cond_d);

        if (r.st == ST_IDLE && |cond) begin
            ix = rst_idx(first_code);
            tbase = gesture ? 8'h00 : r.tally[first_code];
            n.code = first_code;
            n.tally[first_code] = (tbase == 8'hFF) ? tbase : tbase + 8'h01;
            n.hist[n.hptr] = {1'b1, first_code};
            n.hptr = n.hptr + 3'h1;
            n.tick = 25'h0;
            if (!NON_RESTARTABLE[first_code] && r.permit && r.auto_mode
                && r.limit[ix] != 8'h00 && tbase < r.limit[ix]) begin
                n.st = ST_COUNTDOWN;
                n.secs = r.delay[ix];
            end else begin
                n.st = ST_HELD;
            end
        end else if (r.st == ST_COUNTDOWN && n.st == ST_COUNTDOWN) begin
            if (r.secs == 8'h00) begin
                n.restart = 1'b1;
                n.st = ST_IDLE;
            end else if (r.tick == 25'(SEC_CYCLES_P - 1)) begin
                n.tick = 25'h0;
                n.secs = r.secs - 8'h01;
            end else begin
                n.tick = r.tick + 25'h1;
            end
        end

        // display refresh sweeps all 64 cells, one per clock
        n.disp_pos = r.disp_pos + 6'h01;
        n.disp.we = 1'b1;
        n.disp.addr = r.disp_pos;
        n.disp.ch = disp_char(r.st, r.code, r.secs, r.disp_pos);

        n.irq = |(n.status & n.mask);
    end

    // power loss is this reset: every trip and message state starts clean
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r <= '0;
            r.st <= ST_IDLE;
            r.limit <= {N_RST{RST_LIMIT}};
            r.delay <= {N_RST{RST_DELAY}};
            r.mask <= RST_MASK;
            r.thresh <= RST_THRESH;
            r.tally <= '0;
        end else begin
            r <= n;
        end
    end

    assign s_axi_awready = r.awready;
    assign s_axi_wready = r.wready;
    assign s_axi_bvalid = r.bvalid;
    assign s_axi_bresp = r.bresp;
    assign s_axi_arready = r.arready;
    assign s_axi_rvalid = r.rvalid;
    assign s_axi_rresp = r.rresp;
    assign s_axi_rdata = r.rdata;
    assign disp = r.disp;
    assign restart_pulse = r.restart;
    assign auto_mode = r.auto_mode;
    assign irq = r.irq;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_phase_loss_hit: assert property (
        (r.st == ST_IDLE && cond == 6'h20) |=> (r.code == T_PHASE_LOSS && r.st != ST_IDLE))
        else $error("phase loss not raised");
    a_nonrst_never: assert property (
        $rose(r.restart) |-> !NON_RESTARTABLE[$past(r.code)])
        else $error("non-restartable trip restarted");
    a_gesture_ignored: assert property (
        (r.st == ST_HELD && NON_RESTARTABLE[r.code] && gesture) |=> r.st == ST_HELD [*2])
        else $error("gesture cleared non-restartable trip");
    a_gesture_clears: assert property (
        (r.st != ST_IDLE && !NON_RESTARTABLE[r.code] && gesture) |=> r.st == ST_IDLE)
        else $error("gesture did not clear trip");
    a_tally_zeroed: assert property (
        (r.st != ST_IDLE && !NON_RESTARTABLE[r.code] && gesture) |=> r.tally == '0)
        else $error("tally not zeroed");
    a_hist_kept: assert property (
        (r.st != ST_IDLE && gesture && !mem_clr) |=> $stable(r.hist))
        else $error("history lost on clear");
    a_limit_default: assert property (
        $rose(aresetn) |-> (r.limit == '0) [*2])
        else $error("restart limit not zero");
    a_permit_needed: assert property (
        (r.st == ST_IDLE && |cond && !r.permit) |=> r.st != ST_COUNTDOWN)
        else $error("restart without permit");
    a_limit_stops: assert property (
        (r.st == ST_IDLE && |cond && !gesture && !NON_RESTARTABLE[first_code]
         && r.tally[first_code] >= r.limit[rst_idx(first_code)]) |=> r.st == ST_HELD)
        else $error("restart beyond limit");
    a_hist_record: assert property (
        (r.st == ST_IDLE && |cond) |=> r.hist[$past(mem_clr) ? 3'h0 : $past(r.hptr)]
                                     == {1'b1, $past(first_code)})
        else $error("trip not logged");
    a_count_down: assert property (
        (r.st == ST_COUNTDOWN && r.secs != 8'h00 && r.tick == 25'(SEC_CYCLES_P - 1)
         && !gesture) |=> r.secs == $past(r.secs) - 8'h01)
        else $error("countdown did not step");

    c_restart_done: cover property (r.st == ST_COUNTDOWN ##1 r.restart);
    c_gesture_clear: cover property (r.st == ST_HELD && gesture ##1 r.st == ST_IDLE);
    c_nonrst_hold: cover property (r.st == ST_HELD && NON_RESTARTABLE[r.code]);
endmodule // fault_restart_supervisor

// ### verilog/fault_restart_pkg.sv
// constants, types and display texts of the fault restart supervisor
// How it works
// - trip text goes to a two-row, thirty-two column character display
// - up+down gesture or power cycle clears a restartable trip
// - either clear zeroes the tally of every trip type
// - tally reset by gesture keeps the history; memory clear or power cycle erases it
// - non-restartable trips never restart automatically
// - non-restartable trips clear only by power cycle, gesture ignored
// - pending restart shown on display with seconds counting down
// - allowed restarts default to zero for every restartable type
// - each restartable type has its own restart limit and delay
// - automatic restart needs the global permit and a nonzero limit
// - with permit set the device starts in auto mode after power-up
// - unbalance above eighty percent raises restartable phase loss trip
// - current below low current threshold raises restartable trip
// - line overcurrent and output short raise non-restartable trips
// - overtemperature and bus overvoltage raise restartable trips
// - no trip message survives a power cycle
package fault_restart_pkg;
    localparam int N_TYPES = 6;
    localparam int N_RST = 4;
    localparam int HIST_DEPTH = 8;
    localparam int DISP_ROWS = 2;
    localparam int DISP_COLS = 32;
    localparam logic [2:0] T_OUT_SHORT = 3'h0;
    localparam logic [2:0] T_LINE_OC = 3'h1;
    localparam logic [2:0] T_OVERTEMP = 3'h2;
    localparam logic [2:0] T_BUS_OV = 3'h3;
    localparam logic [2:0] T_LOW_CUR = 3'h4;
    localparam logic [2:0] T_PHASE_LOSS = 3'h5;
    localparam logic [2:0] T_FIRST_RST = 3'h2;
    localparam logic [5:0] NON_RESTARTABLE = 6'h03;
    // 80 percent
    localparam logic [7:0] UNBAL_LIMIT_PCT = 8'h50;
    localparam int SECOND_MS = 1000;
    localparam int CLK_KHZ = 20000;
    localparam int SEC_CYCLES = SECOND_MS * CLK_KHZ;
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_MASK = 8'h08;
    localparam logic [7:0] ADDR_STATE = 8'h0C;
    localparam logic [7:0] ADDR_THRESH = 8'h10;
    localparam logic [7:0] ADDR_RCFG0 = 8'h20;
    localparam logic [7:0] ADDR_TALLY0 = 8'h30;
    localparam logic [7:0] ADDR_TALLY1 = 8'h34;
    localparam logic [7:0] ADDR_HIST = 8'h38;
    localparam logic [7:0] ADDR_HPTR = 8'h3C;
    localparam int CTRL_AUTO_BIT = 0;
    localparam int CTRL_MEMCLR_BIT = 1;
    localparam logic [7:0] RST_LIMIT = 8'h00;
    localparam logic [7:0] RST_DELAY = 8'h00;
    localparam logic [5:0] RST_MASK = 6'h00;
    localparam logic [15:0] RST_THRESH = 16'h0000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [127:0] MSG_OUT_SHORT = "OUTPUT FAULT    ";
    localparam logic [127:0] MSG_LINE_OC = "INPUT FAULT     ";
    localparam logic [127:0] MSG_OVERTEMP = "OVER TEMPERATURE";
    localparam logic [127:0] MSG_BUS_OV = "BUS OVERVOLTAGE ";
    localparam logic [127:0] MSG_LOW_CUR = "UNDER CURRENT   ";
    localparam logic [127:0] MSG_PHASE = "PHASE LOSS      ";
    localparam logic [127:0] MSG_READY = "READY           ";
    localparam logic [127:0] MSG_RESTART = "RESTART IN     S";
    localparam logic [127:0] MSG_CYCLE = "CYCLE POWER     ";
    localparam logic [127:0] MSG_CLEAR = "PRESS UP + DOWN ";
    localparam logic [127:0] MSG_BLANK = "                ";
    localparam int DIGIT_COL = 11;

    typedef enum logic [1:0] {ST_IDLE, ST_COUNTDOWN, ST_HELD} sup_state_t;

    typedef struct packed {
        logic out_short;
        logic line_oc;
        logic overtemp;
        logic bus_ov;
        logic [15:0] motor_current;
        logic [7:0] unbalance_pct;
    } trip_inputs_t;

    typedef struct packed {
        logic we;
        logic [5:0] addr;
        logic [7:0] ch;
    } display_t;

    typedef struct packed {
        sup_state_t st;
        logic [2:0] code;
        logic [7:0] secs;
        logic [24:0] tick;
        logic [2:0] up_s;
        logic [2:0] dn_s;
        logic [2:0] pm_s;
        logic key_up;
        logic key_dn;
        logic both_d;
        logic permit;
        logic auto_mode;
        logic [2:0] boot;
        logic [5:0] status;
        logic [5:0] mask;
        logic [5:0] cond_d;
        logic [15:0] thresh;
        logic [N_RST-1:0][7:0] limit;
        logic [N_RST-1:0][7:0] delay;
        logic [N_TYPES-1:0][7:0] tally;
        logic [HIST_DEPTH-1:0][3:0] hist;
        logic [2:0] hptr;
        logic restart;
        logic irq;
        logic [5:0] disp_pos;
        display_t disp;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic aw_got;
        logic w_got;
        logic [7:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
    } sup_regs_t;
endpackage

// ### verif/front_panel.sv
// front panel model: keypad, permit switch and display capture
`timescale 1ns/1ns
module front_panel (
    input wire logic aclk,
    input wire fault_restart_pkg::display_t disp,
    output logic key_up_pin,
    output logic key_down_pin,
    output logic restart_permit_pin
);
    import fault_restart_pkg::*;
    logic [7:0] mem [0:63];
    initial begin
        key_up_pin = 1'b0;
        key_down_pin = 1'b0;
        restart_permit_pin = 1'b1;
    end
    always @(posedge aclk) begin
        if (disp.we) begin
            mem[disp.addr] <= disp.ch;
        end
    end
    // keys held well past the input synchronisers; released keys read low
    task press_both(input logic up = 1'b1, input logic dn = 1'b1);
        @(posedge aclk);
        key_up_pin <= up;
        key_down_pin <= dn;
        repeat (8) @(posedge aclk);
        key_up_pin <= 1'b0;
        key_down_pin <= 1'b0;
        repeat (8) @(posedge aclk);
    endtask
    task set_permit(input logic v);
        @(posedge aclk);
        restart_permit_pin <= v;
        repeat (6) @(posedge aclk);
    endtask
    function automatic logic [127:0] row_text(input int row);
        logic [127:0] t;
        for (int i = 0; i < 16; i++) begin
            t[127-8*i -: 8] = mem[row*32+i];
        end
        return t;
    endfunction
endmodule // front_panel

// ### verif/testbench.sv
// self-checking bench of the fault restart supervisor
`timescale 1ns/1ns
module testbench;
    import fault_restart_pkg::*;
    localparam trip_inputs_t IDLE_IN = '{1'b0, 1'b0, 1'b0, 1'b0, 16'h0064, 8'h50};
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid;
    trip_inputs_t trip_in;
    display_t disp;
    logic key_up_pin, key_down_pin, restart_permit_pin, restart_pulse, auto_mode, irq;
    int n_errors = 0;
    int checked = 0;
    always #25 aclk = ~aclk;
    // one second shrunk to 20 cycles so countdowns stay short
    fault_restart_supervisor #(.SEC_CYCLES_P(20)) dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .trip_in(trip_in), .key_up_pin(key_up_pin), .key_down_pin(key_down_pin),
        .restart_permit_pin(restart_permit_pin), .disp(disp), .restart_pulse(restart_pulse),
        .auto_mode(auto_mode), .irq(irq));
    front_panel panel (.aclk(aclk), .disp(disp), .key_up_pin(key_up_pin),
        .key_down_pin(key_down_pin), .restart_permit_pin(restart_permit_pin));
    task end_sim();
        if (n_errors == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task chk(input string nm, input logic [127:0] seen, input logic [127:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask
    task axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF,
                input int bw = 0);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        // bw above zero holds the response back to see that it stands
        bready <= (bw == 0);
        do begin
            @(posedge aclk);
            if (awvalid && awready === 1'b1) awvalid <= 1'b0;
            if (wvalid && wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        if (bw > 0) begin
            repeat (bw) @(posedge aclk);
            chk("bvalid stands", bvalid, 1'b1);
            bready <= 1'b1;
            @(posedge aclk);
        end
        bready <= 1'b0;
        chk("bresp", bresp, RESP_OKAY);
    endtask
    task axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arvalid && arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
    task rd_chk(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0] r;
        axi_rd(a, d, r);
        chk(nm, d & m, e);
    endtask
    task do_reset();
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (10) @(posedge aclk);
    endtask
    // a trip condition present for exactly one sampling edge
    task trip(input int code);
        @(posedge aclk);
        case (code)
            0: trip_in.out_short <= 1'b1;
            1: trip_in.line_oc <= 1'b1;
            2: trip_in.overtemp <= 1'b1;
            3: trip_in.bus_ov <= 1'b1;
            4: trip_in.motor_current <= 16'h0063;
            default: trip_in.unbalance_pct <= 8'h51;
        endcase
        @(posedge aclk);
        trip_in <= IDLE_IN;
        repeat (3) @(posedge aclk);
    endtask
    task t_reset_values();
        logic [31:0] d;
        logic [1:0] r;
        chk("auto_mode", auto_mode, 1'b1);
        rd_chk("mask", ADDR_MASK, 32'hFFFFFFFF, 32'h0);
        for (int i = 0; i < 4; i++) rd_chk("rcfg", ADDR_RCFG0 + 8'(4*i), '1, 32'h0);
        rd_chk("state", ADDR_STATE, 32'h0003FFFF, 32'h00030000);
        axi_rd(8'h40, d, r);
        chk("unmapped", r, RESP_SLVERR);
    endtask
    task t_restart();
        int n;
        axi_wr(ADDR_RCFG0, 32'h00000801);
        trip(2);
        rd_chk("countdown", ADDR_STATE, 32'hFFFF, 32'h0809);
        repeat (130) @(posedge aclk);
        chk("restart text", panel.row_text(1) >> 48, MSG_RESTART >> 48);
        chk("heat text", panel.row_text(0), MSG_OVERTEMP);
        n = 0;
        while (restart_pulse !== 1'b1 && n < 400) begin
            @(posedge aclk);
            n++;
        end
        chk("restart pulse", restart_pulse, 1'b1);
        trip(2);
        rd_chk("limit hold", ADDR_STATE, 32'h1F, 32'h0A);
        rd_chk("tally", ADDR_TALLY0, '1, 32'h00020000);
        panel.press_both();
        // idle again; the last trip code stays readable
        rd_chk("cleared", ADDR_STATE, 32'h1F, 32'h08);
        rd_chk("tally zero", ADDR_TALLY0, '1, 32'h0);
        rd_chk("history", ADDR_HIST, '1, 32'h000000AA);
        axi_wr(ADDR_CTRL, 32'h00000003);
        rd_chk("memory clear", ADDR_HIST, '1, 32'h0);
    endtask
    task t_no_permit();
        panel.set_permit(1'b0);
        trip(2);
        rd_chk("no permit", ADDR_STATE, 32'h1F, 32'h0A);
        panel.press_both(1'b1, 1'b0);
        rd_chk("one key", ADDR_STATE, 32'h1F, 32'h0A);
        panel.press_both();
        panel.set_permit(1'b1);
    endtask
    task t_nonrestart();
        trip(0);
        repeat (130) @(posedge aclk);
        rd_chk("no restart", ADDR_STATE, 32'h1F, 32'h02);
        chk("short text", panel.row_text(0), MSG_OUT_SHORT);
        chk("power text", panel.row_text(1), MSG_CYCLE);
        panel.press_both();
        rd_chk("gesture ignored", ADDR_STATE, 32'h1F, 32'h02);
        do_reset();
        repeat (130) @(posedge aclk);
        chk("after power", panel.row_text(0), MSG_READY);
        rd_chk("power clear", ADDR_STATE, 32'h1F, 32'h0);
    endtask
    task t_codes();
        trip(1);
        rd_chk("line trip", ADDR_STATE, 32'h1F, 32'h06);
        do_reset();
        axi_wr(ADDR_THRESH, 32'hAA55FF64, 4'h1);
        rd_chk("strobe", ADDR_THRESH, '1, 32'h64);
        repeat (10) @(posedge aclk);
        rd_chk("boundary", ADDR_STATE, 32'h1F, 32'h0);
        for (int k = 3; k < 6; k++) begin
            trip(k);
            repeat (130) @(posedge aclk);
            rd_chk("code", ADDR_STATE, 32'h1F, 32'(k*4+2));
            chk("text", panel.row_text(0), k == 3 ? MSG_BUS_OV : k == 4 ? MSG_LOW_CUR : MSG_PHASE);
            panel.press_both();
        end
    endtask
    task t_irq();
        rd_chk("status", ADDR_STATUS, '1, 32'h38);
        chk("irq masked", irq, 1'b0);
        axi_wr(ADDR_MASK, 32'h00000008, 4'hF, 3);
        repeat (2) @(posedge aclk);
        chk("irq raised", irq, 1'b1);
        axi_wr(ADDR_STATUS, 32'h00000008);
        repeat (2) @(posedge aclk);
        chk("irq cleared", irq, 1'b0);
        rd_chk("status w1c", ADDR_STATUS, '1, 32'h30);
    endtask
    initial begin
        {awaddr, araddr, wdata} = '0;
        wstrb = 4'hF;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        trip_in = IDLE_IN;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (10) @(posedge aclk);
        t_reset_values();
        t_restart();
        t_no_permit();
        t_nonrestart();
        t_codes();
        t_irq();
        end_sim();
    end
    // the whole sequence needs well under ten thousand cycles
    initial begin
        repeat (40000) @(posedge aclk);
        n_errors++;
        end_sim();
    end
endmodule // testbench
